// ==== fps_pkg.sv ====
package fps_pkg;
  // ****************************************
  // special-function addresses and fields
  // ****************************************
  localparam logic [7:0] PSC_ADDR = 8'h8F;
  localparam logic [7:0] KEY_ADDR = 8'hB7;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int WE_BIT = 0;
  localparam int EE_BIT = 1;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_BYTES = 512;
  localparam int ADDR_W = 16;
  // key read codes
  localparam logic [1:0] KST_LOCKED = 2'h0;
  localparam logic [1:0] KST_FIRST = 2'h1;
  localparam logic [1:0] KST_OPEN = 2'h2;
  localparam logic [1:0] KST_DEAD = 2'h3;
  typedef enum {KEY_IDLE, KEY_HALF, KEY_ARMED, KEY_LOCKED} fps_key_type;
endpackage : fps_pkg

// ==== fps_op_if.sv ====
`timescale 1ns/1ns
// ****************************************
// flash operation request between modules
// ****************************************
interface fps_op_if;
  logic key_wr;
  logic [7:0] key_data;
  logic op_try;
  logic armed;
  logic [1:0] key_state;
  modport ctl (output key_wr, key_data, op_try, input armed, key_state);
  modport key (input key_wr, key_data, op_try, output armed, key_state);
endinterface : fps_op_if

// ==== fps_key_lock.sv ====
`timescale 1ns/1ns
// ****************************************
// key sequence and lock state
// ****************************************
module fps_key_lock (
  input wire logic clk,
  input wire logic arst_n,
  fps_op_if.key op
);
  import fps_pkg::*;
  fps_key_type st_r;
  fps_key_type st_nxt;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      KEY_IDLE: begin
        if (op.op_try) st_nxt = KEY_LOCKED;
        else if (op.key_wr) begin
          st_nxt = (op.key_data == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
        end
      end
      KEY_HALF: begin
        if (op.op_try) st_nxt = KEY_LOCKED;
        else if (op.key_wr) begin
          st_nxt = (op.key_data == KEY_SECOND) ? KEY_ARMED : KEY_LOCKED;
        end
      end
      KEY_ARMED: begin
        if (op.op_try) st_nxt = KEY_IDLE;
        else if (op.key_wr) st_nxt = KEY_LOCKED;
      end
      KEY_LOCKED: st_nxt = KEY_LOCKED;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_r <= KEY_IDLE;
    else st_r <= st_nxt;
  end
  assign op.armed = (st_r == KEY_ARMED);
  assign op.key_state = (st_r == KEY_HALF) ? KST_FIRST :
                        (st_r == KEY_ARMED) ? KST_OPEN :
                        (st_r == KEY_LOCKED) ? KST_DEAD : KST_LOCKED;

  sequence s_first_key;
    st_r == KEY_IDLE && op.key_wr && !op.op_try
      && op.key_data == KEY_FIRST;
  endsequence
  sequence s_second_key;
    st_r == KEY_HALF && op.key_wr && !op.op_try
      && op.key_data == KEY_SECOND;
  endsequence

  a_lock_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    st_r == KEY_LOCKED |=> st_r == KEY_LOCKED)
    else $error("lock state left before reset");
  a_disarm_after_op: assert property (
    @(posedge clk) disable iff (!arst_n)
    st_r == KEY_ARMED && op.op_try |=> st_r == KEY_IDLE)
    else $error("not disarmed after operation");
  a_first_key: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_first_key |=> st_r == KEY_HALF)
    else $error("first key not taken");
  a_second_key: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_second_key |=> op.armed)
    else $error("second key did not arm");
endmodule : fps_key_lock

// ==== fps_store_ctl.sv ====
`timescale 1ns/1ns
module fps_store_ctl #(
  parameter int PAGE_SIZE = fps_pkg::PAGE_BYTES
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic POR_EVENT,
  input wire logic MON_ON,
  input wire logic MON_RST_ON,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic XWR,
  input wire logic [fps_pkg::ADDR_W-1:0] XADDR,
  input wire logic [7:0] XWDATA,
  input wire logic IRQ_PENDING,
  output logic [7:0] SFR_RDATA,
  output logic FLASH_WR,
  output logic FLASH_ERASE,
  output logic [fps_pkg::ADDR_W-1:0] FLASH_ADDR,
  output logic [7:0] FLASH_DATA,
  output logic XRAM_WR,
  output logic IRQ_HOLD,
  output logic FLASH_ERR_RST,
  output logic MON_FORCE_ON
);
  import fps_pkg::*;
  localparam int PB = $clog2(PAGE_SIZE);

  // ****************************************
  // parameter check
  // ****************************************
  if (PAGE_SIZE < 2 || (PAGE_SIZE & (PAGE_SIZE - 1)) != 0 ||
      PAGE_SIZE >= (1 << ADDR_W)) begin : g_bad_page
    $error("PAGE_SIZE must be a power of two inside the address space");
  end

  // ****************************************
  // special-function decode
  // ****************************************
  function automatic logic sfr_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target);
    sfr_hit = strobe && addr == target;
  endfunction : sfr_hit

  wire psc_sel = sfr_hit(SFR_WR, SFR_ADDR, PSC_ADDR);
  wire key_sel = sfr_hit(SFR_WR, SFR_ADDR, KEY_ADDR);
  wire psc_rd = sfr_hit(SFR_RD, SFR_ADDR, PSC_ADDR);
  wire key_rd = sfr_hit(SFR_RD, SFR_ADDR, KEY_ADDR);

  // ****************************************
  // control register
  // ****************************************
  fps_op_if op();
  logic we_r, ee_r;
  wire we_nxt = psc_sel ? SFR_WDATA[WE_BIT] : we_r;
  wire ee_nxt = psc_sel ? SFR_WDATA[EE_BIT] : ee_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      we_r <= PSC_RESET[WE_BIT];
      ee_r <= PSC_RESET[EE_BIT];
    end else begin
      we_r <= we_nxt;
      ee_r <= ee_nxt;
    end
  end

  // ****************************************
  // key handling
  // ****************************************
  wire to_flash = XWR && we_r;
  wire supply_ok = MON_ON && MON_RST_ON;
  assign op.key_wr = key_sel;
  assign op.key_data = SFR_WDATA;
  assign op.op_try = to_flash && supply_ok;
  fps_key_lock u_key (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .op(op)
  );

  // ****************************************
  // flash cycles
  // ****************************************
  function automatic logic [ADDR_W-1:0] page_base(
    input logic [ADDR_W-1:0] a);
    page_base = {a[ADDR_W-1:PB], {PB{1'b0}}};
  endfunction : page_base

  wire do_op = op.op_try && op.armed;
  wire do_erase = do_op && ee_r;
  wire do_write = do_op && !ee_r;
  wire xram_nxt = XWR && !we_r;
  wire err_nxt = to_flash && !supply_ok;
  wire [ADDR_W-1:0] fa_nxt = do_erase ? page_base(XADDR) : XADDR;
  wire [7:0] fd_nxt = do_erase ? ERASED_BYTE : XWDATA;
  wire [ADDR_W-1:0] fa_hold = do_op ? fa_nxt : FLASH_ADDR;
  wire [7:0] fd_hold = do_op ? fd_nxt : FLASH_DATA;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLASH_WR <= 1'b0;
      FLASH_ERASE <= 1'b0;
      IRQ_HOLD <= 1'b0;
    end else begin
      FLASH_WR <= do_write;
      FLASH_ERASE <= do_erase;
      IRQ_HOLD <= do_op;
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLASH_ADDR <= '0;
      FLASH_DATA <= '0;
    end else begin
      FLASH_ADDR <= fa_hold;
      FLASH_DATA <= fd_hold;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  wire [7:0] rd_nxt = psc_rd ? {6'h00, ee_r, we_r} :
    key_rd ? {6'h00, op.key_state} : 8'h00;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) SFR_RDATA <= '0;
    else SFR_RDATA <= rd_nxt;
  end

  // ****************************************
  // routing, error reset and monitor force
  // ****************************************
  logic por_seen_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      XRAM_WR <= 1'b0;
      FLASH_ERR_RST <= 1'b0;
      por_seen_r <= 1'b0;
      MON_FORCE_ON <= 1'b0;
    end else begin
      XRAM_WR <= xram_nxt;
      FLASH_ERR_RST <= err_nxt;
      por_seen_r <= POR_EVENT;
      MON_FORCE_ON <= por_seen_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_try_any;
    XWR && we_r && MON_ON && MON_RST_ON && op.armed;
  endsequence
  sequence s_try_write;
    XWR && we_r && !ee_r && MON_ON && MON_RST_ON && op.armed;
  endsequence
  sequence s_try_erase;
    XWR && we_r && ee_r && MON_ON && MON_RST_ON && op.armed;
  endsequence
  sequence s_por_seen;
    POR_EVENT ##1 1'b1;
  endsequence

  a_err_on_supply: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    XWR && we_r && !(MON_ON && MON_RST_ON) |=> FLASH_ERR_RST)
    else $error("no flash error reset without supply monitor");
  a_no_op_no_supply: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    !(MON_ON && MON_RST_ON) |=> !FLASH_WR && !FLASH_ERASE)
    else $error("flash modified without supply monitor");
  a_no_erase_off: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    !ee_r |=> !FLASH_ERASE)
    else $error("erase without erase enable");
  a_erase_all_ones: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    FLASH_ERASE |-> FLASH_DATA == ERASED_BYTE
      && FLASH_ADDR[PB-1:0] == '0)
    else $error("erase not page aligned all ones");
  a_route_xram: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    XWR && !we_r |=> XRAM_WR && !FLASH_WR)
    else $error("write enable off but no xram write");
  a_psc_upper_zero: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    $past(psc_rd) |-> SFR_RDATA[7:EE_BIT+1] == '0)
    else $error("control upper bits not zero");
  a_irq_hold_op: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    FLASH_WR || FLASH_ERASE |-> IRQ_HOLD)
    else $error("interrupt not held during flash op");
  a_por_monitor: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_por_seen |=> MON_FORCE_ON)
    else $error("monitor not forced on after power-on");
  a_write_pulse: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_try_write |=> FLASH_WR && !FLASH_ERASE
      && FLASH_ADDR == $past(XADDR) && FLASH_DATA == $past(XWDATA))
    else $error("armed write did not program the byte");
  a_erase_pulse: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_try_erase |=> FLASH_ERASE && !FLASH_WR
      && FLASH_ADDR[ADDR_W-1:PB] == $past(XADDR[ADDR_W-1:PB]))
    else $error("armed erase did not hit the page");
  a_hold_on_try: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    s_try_any |=> IRQ_HOLD)
    else $error("interrupt not held for armed operation");
  a_erase_both: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    FLASH_ERASE |-> $past(we_r && ee_r))
    else $error("erase without both enables");
  a_no_op_unarmed: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    !op.armed |=> !FLASH_WR && !FLASH_ERASE)
    else $error("flash modified while disarmed");
  a_rdata_idle: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    !SFR_RD |=> SFR_RDATA == '0)
    else $error("read data not zero without read");
  a_key_readback: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    key_rd |=> SFR_RDATA == {6'h00, $past(op.key_state)})
    else $error("key state read back wrong");
endmodule : fps_store_ctl

// ==== fps_cpu_model.sv ====
`timescale 1ns/1ns
// ****************************************
// cpu side: register and external write cycles
// ****************************************
module fps_cpu_model (
  input wire logic REF_CLK,
  output logic SFR_WR,
  output logic SFR_RD,
  output logic [7:0] SFR_ADDR,
  output logic [7:0] SFR_WDATA,
  output logic XWR,
  output logic [fps_pkg::ADDR_W-1:0] XADDR,
  output logic [7:0] XWDATA
);
  import fps_pkg::*;
  initial begin
    {SFR_WR, SFR_RD, XWR} = 3'h0;
    {SFR_ADDR, SFR_WDATA, XADDR, XWDATA} = '0;
  end
  // released data shows the inverse of the last value
  task automatic sfr(input logic w, input logic [7:0] a, d);
    @(negedge REF_CLK);
    SFR_WR = w;
    SFR_RD = !w;
    SFR_ADDR = a;
    SFR_WDATA = d;
    @(negedge REF_CLK);
    SFR_WR = 1'h0;
    SFR_RD = 1'h0;
    SFR_ADDR = ~a;
    SFR_WDATA = ~d;
  endtask : sfr
  // monitor inputs are left as the bench last set them
  task automatic xw(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge REF_CLK);
    XWR = 1'h1;
    XADDR = a;
    XWDATA = d;
    @(negedge REF_CLK);
    XWR = 1'h0;
    XADDR = ~a;
    XWDATA = ~d;
  endtask : xw
endmodule : fps_cpu_model

// ==== fps_store_ctl_bench.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
// ****************************************
// bench for the program store control
// ****************************************
module fps_store_ctl_bench;
  import fps_pkg::*;
  logic REF_CLK, ARST_N, POR_EVENT, MON_ON, MON_RST_ON, IRQ_PENDING;
  logic SFR_WR, SFR_RD, XWR, FLASH_WR, FLASH_ERASE, XRAM_WR, IRQ_HOLD;
  logic FLASH_ERR_RST, MON_FORCE_ON;
  logic [7:0] SFR_ADDR, SFR_WDATA, XWDATA, SFR_RDATA, FLASH_DATA, rd;
  logic [ADDR_W-1:0] XADDR, FLASH_ADDR;
  logic [4:0] ev;
  int checks = 0;
  int n_mismatch = 0;
  wire [4:0] evw = {FLASH_WR, FLASH_ERASE, XRAM_WR, IRQ_HOLD, FLASH_ERR_RST};
  fps_cpu_model u_cpu (.REF_CLK(REF_CLK), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .XWR(XWR), .XADDR(XADDR),
    .XWDATA(XWDATA));
  fps_store_ctl #(.PAGE_SIZE(512)) u_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .POR_EVENT(POR_EVENT), .MON_ON(MON_ON), .MON_RST_ON(MON_RST_ON),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .XWR(XWR), .XADDR(XADDR), .XWDATA(XWDATA),
    .IRQ_PENDING(IRQ_PENDING), .SFR_RDATA(SFR_RDATA), .FLASH_WR(FLASH_WR),
    .FLASH_ERASE(FLASH_ERASE), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_DATA(FLASH_DATA), .XRAM_WR(XRAM_WR), .IRQ_HOLD(IRQ_HOLD),
    .FLASH_ERR_RST(FLASH_ERR_RST), .MON_FORCE_ON(MON_FORCE_ON));
  initial begin
    REF_CLK = 1'h0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  task automatic conclude();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic obs();
    rd = SFR_RDATA;
    ev = evw;
    @(negedge REF_CLK);
    rd |= SFR_RDATA;
    ev |= evw;
  endtask : obs
  task automatic rdr(input logic [7:0] a);
    u_cpu.sfr(1'h0, a, 8'h00);
    obs();
  endtask : rdr
  task automatic xw(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    u_cpu.xw(a, d);
    obs();
  endtask : xw
  task automatic rst();
    ARST_N = 1'h0;
    repeat (10) @(negedge REF_CLK);
    ARST_N = 1'h1;
  endtask : rst
  task automatic start(input logic [7:0] psc);
    rst();
    u_cpu.sfr(1'h1, PSC_ADDR, psc);
    u_cpu.sfr(1'h1, KEY_ADDR, KEY_FIRST);
    u_cpu.sfr(1'h1, KEY_ADDR, KEY_SECOND);
  endtask : start
  task automatic t_regs();
    rst();
    rdr(PSC_ADDR);
    `CHK("control", PSC_RESET, rd)
    rdr(KEY_ADDR);
    `CHK("key", KST_LOCKED, rd[1:0])
    u_cpu.sfr(1'h1, PSC_ADDR, 8'hFF);
    rdr(PSC_ADDR);
    `CHK("control", 8'h03, rd)
    u_cpu.sfr(1'h1, KEY_ADDR, KEY_FIRST);
    rdr(KEY_ADDR);
    `CHK("key", KST_FIRST, rd[1:0])
    u_cpu.sfr(1'h1, KEY_ADDR, 8'h11);
    rdr(KEY_ADDR);
    `CHK("key", KST_DEAD, rd[1:0])
  endtask : t_regs
  task automatic t_write();
    start(8'h01);
    rdr(KEY_ADDR);
    `CHK("key", KST_OPEN, rd[1:0])
    xw(16'h1234, 8'h5A);
    `CHK("events", 5'h12, ev)
    `CHK("addr", 16'h1234, FLASH_ADDR)
    `CHK("data", 8'h5A, FLASH_DATA)
    xw(16'h1235, 8'h00);
    `CHK("events", 5'h00, ev)
    rdr(KEY_ADDR);
    `CHK("key", KST_DEAD, rd[1:0])
  endtask : t_write
  task automatic t_erase();
    start(8'h03);
    xw(16'h13FE, 8'h00);
    `CHK("events", 5'h0A, ev)
    `CHK("addr", 16'h1200, FLASH_ADDR)
    `CHK("data", ERASED_BYTE, FLASH_DATA)
  endtask : t_erase
  task automatic t_supply();
    start(8'h01);
    MON_RST_ON = 1'h0;
    xw(16'h0040, 8'h12);
    `CHK("events", 5'h01, ev)
    {MON_ON, MON_RST_ON} = 2'h1;
    xw(16'h0040, 8'h12);
    `CHK("events", 5'h01, ev)
    MON_ON = 1'h1;
    xw(16'h0040, 8'h12);
    `CHK("events", 5'h12, ev)
    start(8'h02);
    xw(16'h0040, 8'h12);
    `CHK("events", 5'h04, ev)
  endtask : t_supply
  task automatic t_por();
    int n;
    POR_EVENT = 1'h1;
    @(negedge REF_CLK);
    POR_EVENT = 1'h0;
    for (n = 0; n < 4 && MON_FORCE_ON !== 1'h1; n++) @(negedge REF_CLK);
    `CHK("force on", 1'h1, MON_FORCE_ON)
    if (MON_FORCE_ON !== 1'h1) conclude();
  endtask : t_por
  initial begin
    {ARST_N, POR_EVENT} = 2'h0;
    {MON_ON, MON_RST_ON, IRQ_PENDING} = 3'h7;
    t_regs();
    t_write();
    t_erase();
    t_supply();
    t_por();
    conclude();
  end
endmodule : fps_store_ctl_bench
